// [logic/prog_port_pkg.sv]
// constants shared by the serial programming port
package prog_port_pkg;

  // command framing
  localparam int CMD_BITS = 6;
  localparam logic [3:0] CMD_LAST_BIT = 4'h5;
  localparam logic [3:0] DATA_LAST_CLOCK = 4'hF;
  localparam logic [3:0] DATA_FIRST_BIT = 4'h1;
  localparam logic [3:0] DATA_LAST_BIT = 4'hE;
  localparam int WORD_BITS = 14;
  localparam int STORE_BITS = 12;

  // low four command bits; the upper two are ignored
  localparam logic [3:0] CMD_LOAD = 4'h2;
  localparam logic [3:0] CMD_READ = 4'h4;
  localparam logic [3:0] CMD_INCR = 4'h6;
  localparam logic [3:0] CMD_BEGIN = 4'h8;
  localparam logic [3:0] CMD_END = 4'hE;
  localparam logic [3:0] CMD_ERASE = 4'h9;

  // address map, smaller and larger part
  localparam int ADDR_W = 11;
  localparam int MEM_WORDS = 2048;
  localparam logic [10:0] ADDR_MASK_SMALL = 11'h3FF;
  localparam logic [10:0] ADDR_MASK_LARGE = 11'h7FF;
  localparam logic [10:0] USER_TOP_SMALL = 11'h1FF;
  localparam logic [10:0] USER_TOP_LARGE = 11'h3FF;
  localparam logic [10:0] ID_BASE_SMALL = 11'h200;
  localparam logic [10:0] ID_BASE_LARGE = 11'h400;
  localparam logic [10:0] CFG_REGION_SPAN = 11'h03F;
  localparam logic [10:0] PROTECT_LOW = 11'h040;
  localparam logic [10:0] ADDR_ZERO = 11'h000;

  // device option word layout
  localparam int OPT_OSC_LSB = 0;
  localparam int OPT_WATCHDOG = 2;
  localparam int OPT_PROTECT = 3;
  localparam int OPT_RESET_PIN = 4;
  localparam int OPT_USED = 5;
  localparam logic [4:0] OPT_ERASED = 5'h1F;
  localparam logic [6:0] OPT_UNUSED_READ = 7'h7F;
  localparam logic [11:0] WORD_ERASED = 12'hFFF;
  localparam logic [1:0] OSC_LOW_POWER_CRYSTAL = 2'h0;
  localparam logic [1:0] OSC_STANDARD_CRYSTAL = 2'h1;
  localparam logic [1:0] OSC_INTERNAL_RC = 2'h2;
  localparam logic [1:0] OSC_EXTERNAL_RC = 2'h3;

  // timing
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int PROGRAM_CYCLE_TIME_NS = 1000000;
  localparam int ERASE_TIME_NS = 6000000;
  localparam int PROGRAM_CYCLES =
    (PROGRAM_CYCLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int ERASE_CYCLES = ERASE_TIME_NS / CLOCK_PERIOD_NS;
  localparam int COUNT_W = 24;

  typedef enum logic [1:0] {st_idle, st_program, st_erase} engine_state_t;
  typedef enum logic {ph_command, ph_data} link_phase_t;

  // commands that carry a sixteen clock data segment
  function automatic logic has_data(input logic [3:0] code);
    has_data = (code == CMD_LOAD) || (code == CMD_READ);
  endfunction

endpackage

// [logic/serial_program_verify_port.sv]
// serial programming port: link shifter, command engine and program memory
// Operation
// - a command is six programming clocks, one bit per clock.
// - command bits are sampled on the falling clock edge, lsb first.
// - load and read are followed by a sixteen clock data segment.
// - first and last data clocks are start and stop; data ignored.
// - fourteen middle clocks carry data lsb first in both directions.
// - on read, drive pin from second data rise, release at sixteenth rise.
// - load keeps twelve bits in the write latch, drops the top two.
// - read returns the addressed word with the top two bits zero.
// - address only increments, wraps from configuration top to zero.
// - begin programming writes the latch without erasing, ended externally.
// - end programming stops the write; programmer waits discharge delay.
// - bulk erase sets program memory and option word to all ones.
// - erase at first user id location also clears ids and backup trim.
// - option bits read one unprogrammed; bits eleven to five read one.
// - bit four selects reset pin, bit two enables the watchdog.
// - bits one and zero select the oscillator type.
// - with protection on, 0x040 to below last user word read zero.
// - ids, backup trim and option word stay readable and programmable.
// - only bulk erase after mode entry removes protection.
// - low four command bits decode the six commands.
// - mode entry sets the address to the option word location.
// - option word reachable only before the first increment.
module serial_program_verify_port
  import prog_port_pkg::*;
#(
  parameter bit LARGE_PART = 1'b1,
  parameter int PROG_CYCLES = PROGRAM_CYCLES,
  parameter int ERASE_WAIT_CYCLES = ERASE_CYCLES
) (
  // system clock and mode entry reset
  input wire logic clock,
  input wire logic rst,
  // programming link
  input wire logic prog_clock_pin,
  input wire logic prog_data_in,
  output logic prog_data_out,
  output logic prog_data_oe,
  // option word fields
  output logic reset_pin_enable,
  output logic protect_n,
  output logic watchdog_enable,
  output logic [1:0] osc_select,
  // engine status
  output logic program_active,
  output logic erase_busy
);

  localparam logic [10:0] ADDR_MASK = LARGE_PART ? ADDR_MASK_LARGE : ADDR_MASK_SMALL;
  localparam logic [10:0] USER_TOP = LARGE_PART ? USER_TOP_LARGE : USER_TOP_SMALL;
  localparam logic [10:0] ID_BASE = LARGE_PART ? ID_BASE_LARGE : ID_BASE_SMALL;
  localparam logic [COUNT_W-1:0] PROG_LIMIT = COUNT_W'(PROG_CYCLES);
  localparam logic [COUNT_W-1:0] ERASE_LIMIT = COUNT_W'(ERASE_WAIT_CYCLES);
  localparam logic [COUNT_W-1:0] SWEEP_END = COUNT_W'(MEM_WORDS);

  // ---------------- link domain ----------------
  // held in reset by the system domain; the link clock stands still at mode
  // entry, so release never meets a link edge
  logic link_hold;
  link_phase_t phase;
  logic [3:0] bit_count;
  logic [5:0] cmd_shift;
  logic [3:0] cmd_code;
  logic data_is_read;
  logic [13:0] load_shift;
  logic cmd_toggle;
  logic [13:0] out_shift;
  logic [11:0] read_word;

  always_ff @(posedge clock) begin
    link_hold <= rst;
  end

  always_ff @(negedge prog_clock_pin or posedge link_hold) begin
    if (link_hold) begin
      phase <= ph_command;
      bit_count <= 4'h0;
      cmd_shift <= 6'h00;
      cmd_code <= 4'h0;
      data_is_read <= 1'b0;
      cmd_toggle <= 1'b0;
    end else begin
      case (phase)
        ph_command: begin
          cmd_shift <= {prog_data_in, cmd_shift[5:1]};
          if (bit_count == CMD_LAST_BIT) begin
            bit_count <= 4'h0;
            cmd_code <= cmd_shift[4:1];
            data_is_read <= (cmd_shift[4:1] == CMD_READ);
            if (has_data(cmd_shift[4:1])) begin
              phase <= ph_data;
            end
            // a read is handed over now so the word is ready before data
            if (!has_data(cmd_shift[4:1]) || cmd_shift[4:1] == CMD_READ) begin
              cmd_toggle <= ~cmd_toggle;
            end
          end else begin
            bit_count <= bit_count + 4'h1;
          end
        end
        ph_data: begin
          if (bit_count == DATA_LAST_CLOCK) begin
            phase <= ph_command;
            bit_count <= 4'h0;
            if (!data_is_read) begin
              cmd_toggle <= ~cmd_toggle;
            end
          end else begin
            bit_count <= bit_count + 4'h1;
          end
        end
        default: phase <= ph_command;
      endcase
    end
  end

  always_ff @(negedge prog_clock_pin or posedge link_hold) begin
    if (link_hold) begin
      load_shift <= 14'h0000;
    end else if (phase == ph_data && !data_is_read && bit_count >= DATA_FIRST_BIT
                 && bit_count <= DATA_LAST_BIT) begin
      load_shift <= {prog_data_in, load_shift[13:1]};
    end
  end

  always_ff @(posedge prog_clock_pin or posedge link_hold) begin
    if (link_hold) begin
      out_shift <= 14'h0000;
      prog_data_oe <= 1'b0;
    end else if (phase == ph_data && data_is_read) begin
      if (bit_count == 4'h0) begin
        // read_word is written early in the command gap and is stable by this first data rise
        // top bits zero
        out_shift <= {2'b00, read_word};
      end else if (bit_count == DATA_FIRST_BIT) begin
        prog_data_oe <= 1'b1;
      end else if (bit_count == DATA_LAST_CLOCK) begin
        prog_data_oe <= 1'b0;
      end else begin
        out_shift <= {1'b0, out_shift[13:1]};
      end
    end else begin
      prog_data_oe <= 1'b0;
    end
  end

  assign prog_data_out = out_shift[0];

  // ---------------- system domain ----------------
  logic [2:0] toggle_sync;
  logic cmd_event;
  engine_state_t state;
  logic [COUNT_W-1:0] count;
  logic [10:0] pc;
  logic option_visible;
  logic [11:0] write_latch;
  logic [4:0] option_bits = OPT_ERASED;
  logic [11:0] mem [0:MEM_WORDS-1];
  logic erase_full;
  logic [10:0] sweep_addr;
  logic [11:0] stored_word;
  logic at_option;

  // toggle crossing; only the second and third stages are compared
  always_ff @(posedge clock) begin
    if (rst) begin
      toggle_sync <= 3'h0;
    end else begin
      toggle_sync <= {toggle_sync[1:0], cmd_toggle};
    end
  end

  // cmd_code and load_shift are quiet whenever the toggle moves
  assign cmd_event = toggle_sync[2] ^ toggle_sync[1];
  assign at_option = option_visible && pc == ADDR_MASK;
  assign sweep_addr = count[10:0];

  function automatic logic erasable(input logic [10:0] a, input logic full);
    erasable = (a <= USER_TOP) || (full && a >= ID_BASE && a <= ID_BASE + CFG_REGION_SPAN);
  endfunction

  // command engine; erase busy blocks all commands
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= st_idle;
      count <= '0;
      erase_full <= 1'b0;
    end else begin
      case (state)
        st_idle: begin
          count <= '0;
          if (cmd_event && cmd_code == CMD_BEGIN) begin
            state <= st_program;
          end else if (cmd_event && cmd_code == CMD_ERASE) begin
            erase_full <= (pc == ID_BASE);
            state <= st_erase;
          end
        end
        st_program: begin
          if (count != PROG_LIMIT) begin
            count <= count + 1'b1;
          end
          if (cmd_event && cmd_code == CMD_END) begin
            state <= st_idle;
          end
        end
        st_erase: begin
          count <= count + 1'b1;
          if (count >= ERASE_LIMIT && count >= SWEEP_END) begin
            state <= st_idle;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pc <= ADDR_MASK;
      option_visible <= 1'b1;
    end else if (state == st_idle && cmd_event && cmd_code == CMD_INCR) begin
      pc <= (pc + 11'h001) & ADDR_MASK;
      option_visible <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      write_latch <= WORD_ERASED;
    end else if (state == st_idle && cmd_event && cmd_code == CMD_LOAD) begin
      write_latch <= load_shift[STORE_BITS-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (state == st_erase && count < SWEEP_END && erasable(sweep_addr, erase_full)) begin
      mem[sweep_addr] <= WORD_ERASED;
    end else if (state == st_program && cmd_event && cmd_code == CMD_END
                 && count == PROG_LIMIT && !at_option) begin
      mem[pc] <= mem[pc] & write_latch;
    end
  end

  // option word is nonvolatile: mode entry leaves it alone
  always_ff @(posedge clock) begin
    if (state == st_erase && count == '0) begin
      option_bits <= OPT_ERASED;
    end else if (state == st_program && cmd_event && cmd_code == CMD_END
                 && count == PROG_LIMIT && at_option) begin
      option_bits <= option_bits & write_latch[OPT_USED-1:0];
    end
  end

  assign stored_word = mem[pc];

  always_ff @(posedge clock) begin
    if (rst) begin
      read_word <= 12'h000;
    end else if (state == st_idle && cmd_event && cmd_code == CMD_READ) begin
      if (at_option) begin
        read_word <= {OPT_UNUSED_READ, option_bits};
      end else if (!option_bits[OPT_PROTECT] && pc >= PROTECT_LOW && pc < USER_TOP) begin
        read_word <= 12'h000;
      end else begin
        read_word <= stored_word;
      end
    end
  end

  // other codes fall through every decode above

  assign reset_pin_enable = option_bits[OPT_RESET_PIN];
  assign protect_n = option_bits[OPT_PROTECT];
  assign watchdog_enable = option_bits[OPT_WATCHDOG];
  assign osc_select = option_bits[OPT_OSC_LSB +: 2];
  assign program_active = (state == st_program);
  assign erase_busy = (state == st_erase);

endmodule // serial_program_verify_port

// [verif/prog_port_chk.sv]
// assertion checker for the serial programming port
module prog_port_chk
  import prog_port_pkg::*;
(
  // clocks and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic prog_clock_pin,
  // pin, option fields and status
  input wire logic prog_data_out,
  input wire logic prog_data_oe,
  input wire logic reset_pin_enable,
  input wire logic protect_n,
  input wire logic watchdog_enable,
  input wire logic [1:0] osc_select,
  input wire logic program_active,
  input wire logic erase_busy
);
  logic [4:0] opt;
  logic [4:0] oe_cnt = 5'h00;
  logic [23:0] busy_cnt = 24'h000000;
  logic [2:0] quiet = 3'h0;
  assign opt = {reset_pin_enable, protect_n, watchdog_enable, osc_select};
  always_ff @(posedge prog_clock_pin) begin
    oe_cnt <= prog_data_oe ? oe_cnt + 5'h01 : 5'h00;
  end
  // idle count saturates so it never wraps back under the limit
  always_ff @(posedge clock) begin
    busy_cnt <= erase_busy ? busy_cnt + 24'h000001 : 24'h000000;
    quiet <= (program_active || erase_busy) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
  end
  a_oe_fourteen: assert property (@(posedge prog_clock_pin) disable iff (rst)
    $fell(prog_data_oe) |-> oe_cnt == 5'h0E) else $error("pin not driven for 14 clocks");
  a_top_zero: assert property (@(posedge prog_clock_pin) disable iff (rst)
    prog_data_oe && oe_cnt >= 5'h0C |-> !prog_data_out) else $error("top read bits not zero");
  a_rise_only: assert property (@(posedge clock) disable iff (rst)
    !$stable(prog_data_oe) || (prog_data_oe && !$stable(prog_data_out)) |-> prog_clock_pin)
    else $error("pin changed away from a rising edge");
  a_busy_long: assert property (@(posedge clock) disable iff (rst)
    $fell(erase_busy) |-> busy_cnt >= MEM_WORDS - 2) else $error("erase ended early");
  a_erase_ones: assert property (@(posedge clock) disable iff (rst)
    $fell(erase_busy) |-> opt == 5'h1F) else $error("option word not erased");
  a_busy_alone: assert property (@(posedge clock) disable iff (rst)
    erase_busy |-> !program_active && !prog_data_oe) else $error("work during erase");
  a_prog_no_read: assert property (@(posedge clock) disable iff (rst)
    program_active |-> !prog_data_oe) else $error("read during program cycle");
  a_opt_quiet: assert property (@(posedge clock) disable iff (rst)
    !$stable(opt) |-> quiet < 3'h3) else $error("option word changed while idle");
  c_read: cover property (@(posedge prog_clock_pin) $fell(prog_data_oe));
  c_erase: cover property (@(posedge clock) $fell(erase_busy));
  c_prog: cover property (@(posedge clock) $fell(program_active));
endmodule // prog_port_chk

// the erase floor is the memory sweep, so no parameter has to be tied here
bind serial_program_verify_port prog_port_chk chk (.clock(clock),
  .rst(rst), .prog_clock_pin(prog_clock_pin), .prog_data_out(prog_data_out),
  .prog_data_oe(prog_data_oe), .reset_pin_enable(reset_pin_enable), .protect_n(protect_n),
  .watchdog_enable(watchdog_enable), .osc_select(osc_select),
  .program_active(program_active), .erase_busy(erase_busy));

// [verif/prog_model.sv]
// programmer model: drives the link clock and the data pin
module prog_model #(
  parameter int HALF_NS = 24,
  parameter int GAP_NS = 200
) (
  // link toward the device
  output logic link_clock,
  output logic drive,
  input wire logic sense
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    link_clock = 1'b0;
    drive = 1'b0;
  end
  task automatic send_cmd(input logic [5:0] code);
    for (int i = 0; i < 6; i++) begin
      #HALF_NS link_clock = 1'b1;
      drive = code[i];
      #HALF_NS link_clock = 1'b0;
    end
    // gap; released line flips so stale data never passes
    drive = ~drive;
    #GAP_NS;
  endtask
  task automatic segment(input logic [13:0] wr, output logic [13:0] rd);
    rd = 14'h0000;
    for (int i = 0; i < 16; i++) begin
      #HALF_NS link_clock = 1'b1;
      drive = (i > 0 && i < 15) ? wr[i-1] : ~drive;
      #HALF_NS;
      if (i > 0 && i < 15) rd[i-1] = sense;
      link_clock = 1'b0;
    end
    drive = ~drive;
    #GAP_NS;
  endtask
endmodule // prog_model

// [verif/tb.sv]
// self-checking bench for the serial programming port
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG_N = 20;
  localparam int ERASE_N = 2100;
  logic clock;
  logic rst = 1'b1;
  logic link_clock, drive, data_wire, prog_data_out, prog_data_oe, program_active, erase_busy;
  wire logic [4:0] opt;
  logic [13:0] rd;
  int n_mismatch = 0;
  int check_count = 0;
  prog_model prog (.link_clock(link_clock), .drive(drive), .sense(data_wire));
  // the device owns the pin only while its enable is high
  assign data_wire = prog_data_oe ? prog_data_out : drive;
  serial_program_verify_port #(.LARGE_PART(1'b0), .PROG_CYCLES(PROG_N),
    .ERASE_WAIT_CYCLES(ERASE_N)) dut (.clock(clock), .rst(rst), .prog_clock_pin(link_clock),
    .prog_data_in(data_wire), .prog_data_out(prog_data_out), .prog_data_oe(prog_data_oe),
    .reset_pin_enable(opt[4]), .protect_n(opt[3]), .watchdog_enable(opt[2]),
    .osc_select(opt[1:0]), .program_active(program_active), .erase_busy(erase_busy));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic enter();
    rst <= 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic status(input string what, input logic [13:0] exp);
    @(negedge clock);
    check(what, {9'h000, opt}, exp);
  endtask
  task automatic read_at(input string what, input logic [13:0] exp);
    prog.send_cmd(6'h04);
    prog.segment(14'h2AAA, rd);
    check(what, rd, exp);
  endtask
  task automatic write_word(input logic [13:0] w);
    prog.send_cmd(6'h02);
    prog.segment(w, rd);
    prog.send_cmd(6'h08);
    repeat (PROG_N + 10) @(negedge clock);
    check("active", {13'h0, program_active}, 14'h0001);
    prog.send_cmd(6'h0E);
    @(negedge clock);
    check("ended", {13'h0, program_active}, 14'h0000);
  endtask
  task automatic erase(input string what);
    prog.send_cmd(6'h09);
    @(negedge clock);
    check("busy", {13'h0, erase_busy}, 14'h0001);
    for (int n = 0; erase_busy !== 1'b0; n++) begin
      if (n == 5000) begin
        check("erase timeout", 14'h0001, 14'h0000);
        results();
      end
      @(negedge clock);
    end
    read_at(what, 14'h0FFF);
  endtask
  task automatic incr(input int n);
    repeat (n) prog.send_cmd(6'h06);
  endtask
  task automatic t_entry();
    read_at("entry word", 14'h0FFF);
    status("entry fields", 14'h001F);
  endtask
  task automatic t_full_erase();
    incr(513);
    erase("id erased");
    write_word(14'h00F5);
    read_at("id written", 14'h00F5);
  endtask
  task automatic t_osc();
    for (int i = 0; i < 4; i++) begin
      erase("option erased");
      write_word(14'h3FFC | 14'(i));
      status("osc", 14'h001C | 14'(i));
    end
    write_word(14'h3FE5);
    status("protect", 14'h0005);
    read_at("option unmasked", 14'h0FE5);
  endtask
  task automatic t_user();
    incr(1);
    write_word(14'h3ABC);
    read_at("wrap word", 14'h0ABC);
    write_word(14'h00F0);
    read_at("no erase", 14'h00B0);
    prog.send_cmd(6'h01);
    read_at("unknown code", 14'h00B0);
    prog.send_cmd(6'h36);
    read_at("next word", 14'h0FFF);
  endtask
  task automatic t_protect();
    incr(63);
    read_at("masked", 14'h0000);
    incr(447);
    read_at("last user", 14'h0FFF);
    incr(1);
    read_at("id kept", 14'h00F5);
    write_word(14'h0005);
    read_at("id programmed", 14'h0005);
    erase("id erased again");
    status("unprotected", 14'h001F);
  endtask
  initial begin
    enter();
    t_entry();
    t_full_erase();
    enter();
    t_entry();
    t_osc();
    t_user();
    t_protect();
    results();
  end
endmodule // tb
